// ---- hw/serial_to_char_lcd_bridge.sv ----
// Serial command stream to character display write bus bridge
`timescale 1ns/10ps
`default_nettype none
`include "lcd_bridge_defines.svh"

module serial_to_char_lcd_bridge
    import lcd_bridge_pkg::*;
#(
    parameter int BIT_LO_CYC = `CLK_HZ / `BAUD_LO,
    parameter int BIT_HI_CYC = `CLK_HZ / `BAUD_HI,
    parameter int SHORT_CYC  = `T_SHORT_US * `CLK_MHZ,
    parameter int LONG_CYC   = int'(`T_LONG_MS * 1000.0 * `CLK_MHZ),
    parameter int DEPTH      = `BUF_DEPTH
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       rx_i,
    input  wire logic       baud_sel_n_i,
    output logic            tx_o,
    output logic            instr_data_select_o,
    output logic            lcd_rw_o,
    output logic            lcd_enable_o,
    output logic [7:0]      lcd_parallel_bus_o,
    output logic            ready_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int TW = `TMR_W;
    localparam int EN_LAG = `SETUP_CYC + 2;

    generate
        if (DEPTH < 2 || DEPTH != (1 << AW) || LONG_CYC >= (1 << TW) ||
            SHORT_CYC >= (1 << TW) || BIT_LO_CYC >= (1 << `BIT_W) ||
            BIT_HI_CYC < 16 || SHORT_CYC < 2) begin : g_bad
            $error("Unsupported bridge parameters");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and baud selection

    logic              rx_s1_r;
    logic              rx_s2_r;
    logic              sel_s1_r;
    logic              sel_s2_r;
    logic [1:0]        settle_r;
    logic              loaded_r;
    logic              rate_hi_r;
    logic [`BIT_W-1:0] bit_cyc_w;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_s1_r  <= 1'b1;
            rx_s2_r  <= 1'b1;
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
        end else begin
            rx_s1_r  <= rx_i;
            rx_s2_r  <= rx_s1_r;
            sel_s1_r <= baud_sel_n_i;
            sel_s2_r <= sel_s1_r;
        end
    end

    // Rate is caught once after reset release, then held
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            settle_r  <= '0;
            loaded_r  <= 1'b0;
            rate_hi_r <= 1'b0;
        end else if (!loaded_r) begin
            if (settle_r == `SETTLE_CYC) begin
                rate_hi_r <= !sel_s2_r;
                loaded_r  <= 1'b1;
            end else begin
                settle_r <= settle_r + 1'b1;
            end
        end
    end

    assign bit_cyc_w = rate_hi_r ? `BIT_W'(BIT_HI_CYC)
                                 : `BIT_W'(BIT_LO_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Serial engines

    byte_link_if rx_bus ();
    byte_link_if tx_bus ();

    logic       echo_go_r;
    logic [7:0] cur_r;

    assign rx_bus.bit_cyc = bit_cyc_w;
    assign rx_bus.line    = rx_s2_r;
    assign tx_bus.bit_cyc = bit_cyc_w;
    assign tx_bus.data    = cur_r;
    assign tx_bus.valid   = echo_go_r;

    async_frame_rx u_rx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .link      (rx_bus.rx)
    );
    async_frame_tx u_tx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .link      (tx_bus.tx)
    );

    ////////////////////////////////////////////////////////////////////////
    // Circular command buffer

    logic [7:0]    mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    logic          full_w;
    logic          push_w;
    logic          pop_w;
    logic          clear_r;
    proc_state_t   st_r;

    assign full_w = (count_r == (AW+1)'(DEPTH));
    assign push_w = rx_bus.valid && loaded_r && !full_w;
    assign pop_w  = (st_r == ST_IDLE) && (count_r != '0) && !clear_r;

    always_ff @(posedge clk_sys_i) begin
        if (push_w) begin
            mem_r[wr_ptr_r] <= rx_bus.data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || clear_r) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(push_w);
            rd_ptr_r <= rd_ptr_r + AW'(pop_w);
            count_r  <= count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command processing and display strobe

    cmd_mode_t     mode_r;
    logic [TW-1:0] tmr_r;
    logic          long_r;
    logic          rs_r;
    logic          en_r;
    logic [7:0]    bus_r;
    logic          is_pfx_w;
    logic          wr_go_w;

    assign is_pfx_w = (cur_r[7:3] == `PFX_TOP);
    assign wr_go_w  = (mode_r == MODE_INSTR) || (mode_r == MODE_DATA) ||
                      ((mode_r == MODE_PLAIN) && !is_pfx_w);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_r      <= ST_IDLE;
            mode_r    <= MODE_PLAIN;
            cur_r     <= '0;
            tmr_r     <= '0;
            long_r    <= 1'b0;
            rs_r      <= 1'b0;
            en_r      <= 1'b0;
            bus_r     <= '0;
            echo_go_r <= 1'b0;
            clear_r   <= 1'b0;
        end else begin
            echo_go_r <= 1'b0;
            clear_r   <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (pop_w) begin
                        cur_r <= mem_r[rd_ptr_r];
                        tmr_r <= TW'(bit_cyc_w) - 1'b1;
                        st_r  <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else if (!tx_bus.busy) begin
                        echo_go_r <= 1'b1;
                        st_r      <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    mode_r <= MODE_PLAIN; // Values after other prefixes drop
                    st_r   <= ST_IDLE;
                    if (wr_go_w) begin
                        rs_r   <= (mode_r != MODE_INSTR);
                        long_r <= (mode_r == MODE_INSTR) &&
                                  ((cur_r == `INS_CLEAR) ||
                                   ((cur_r & `INS_HOME_M) == `INS_HOME));
                        bus_r  <= cur_r;
                        tmr_r  <= TW'(`SETUP_CYC - 1);
                        st_r   <= ST_SETUP;
                    end else if (mode_r == MODE_PLAIN) begin
                        if (cur_r[2:0] == `CMD_RESET) begin
                            clear_r <= 1'b1;
                        end else if (cur_r[2:0] == `CMD_INSTR) begin
                            mode_r <= MODE_INSTR;
                        end else if (cur_r[2:0] == `CMD_DATA) begin
                            mode_r <= MODE_DATA;
                        end else begin
                            mode_r <= MODE_VALUE;
                        end
                    end
                end
                ST_SETUP: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        en_r  <= 1'b1;
                        tmr_r <= TW'(`EN_CYC - 1);
                        st_r  <= ST_ENABLE;
                    end
                end
                ST_ENABLE: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        en_r  <= 1'b0;
                        tmr_r <= TW'(`HOLD_CYC - 1);
                        st_r  <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        tmr_r <= long_r ? TW'(LONG_CYC - 1)
                                        : TW'(SHORT_CYC - 1);
                        st_r  <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_o                <= 1'b1;
            instr_data_select_o <= 1'b0;
            lcd_rw_o            <= 1'b0;
            lcd_enable_o        <= 1'b0;
            lcd_parallel_bus_o  <= '0;
            ready_o             <= 1'b0;
        end else begin
            tx_o                <= tx_bus.line;
            instr_data_select_o <= rs_r;
            lcd_rw_o            <= 1'b0;
            lcd_enable_o        <= en_r;
            lcd_parallel_bus_o  <= bus_r;
            ready_o             <= loaded_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [TW-1:0] en_len_r;
    logic [TW-1:0] gap_r;
    logic [TW-1:0] age_r;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            en_len_r <= '0;
            gap_r    <= '1;
            age_r    <= '0;
        end else begin
            en_len_r <= lcd_enable_o ? en_len_r + 1'b1 : '0;
            if (lcd_enable_o) begin
                gap_r <= '0;
            end else if (gap_r != '1) begin
                gap_r <= gap_r + 1'b1;
            end
            if (pop_w) begin
                age_r <= '0;
            end else if (age_r != '1) begin
                age_r <= age_r + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_rw_write: assert property (lcd_rw_o == 1'b0)
        else $error("Direction line left write state");
    a_en_width: assert property (
        $fell(lcd_enable_o) |-> en_len_r == TW'(`EN_CYC))
        else $error("Enable pulse width wrong");
    a_bus_stable: assert property (
        lcd_enable_o |-> $stable(lcd_parallel_bus_o)
                         && $stable(instr_data_select_o))
        else $error("Bus moved under enable");
    a_rs_instr: assert property (
        st_r == ST_DECODE && mode_r == MODE_INSTR
        |-> ##EN_LAG !instr_data_select_o && lcd_enable_o)
        else $error("Instruction not strobed with select low");
    a_buf_bound: assert property (count_r <= (AW+1)'(DEPTH))
        else $error("Buffer count past depth");
    a_full_drop: assert property (
        full_w && !pop_w && !clear_r |=> full_w)
        else $error("Full buffer lost a byte");
    a_soft_reset: assert property (
        st_r == ST_DECODE && mode_r == MODE_PLAIN && is_pfx_w
        && cur_r[2:0] == `CMD_RESET |=> ##1 count_r <= (AW+1)'(1))
        else $error("Module reset command left buffer filled");
    a_echo_gap: assert property (
        $rose(tx_bus.busy) |-> age_r >= TW'(bit_cyc_w))
        else $error("Echo started too early");
    a_wait_short: assert property (
        $rose(lcd_enable_o) |-> gap_r >= TW'(SHORT_CYC))
        else $error("Display write wait too short");

    c_strobe: cover property ($rose(lcd_enable_o));
    c_full:   cover property (full_w && rx_bus.valid);
    c_reset:  cover property (clear_r);
    c_long:   cover property (st_r == ST_WAIT && long_r);

endmodule : serial_to_char_lcd_bridge

`default_nettype wire

// ---- hw/lcd_bridge_defines.svh ----
// Timing, code and layout constants for the serial LCD bridge
//
// Behaviour
// - Receive frames are one start bit, eight data bits, no parity, one stop.
// - Data bits arrive least significant bit first between start and stop.
// - Receiver runs at 19.2K or 115.2K baud chosen by a jumper input.
// - Open jumper gives 19.2K baud; closed jumper gives 115.2K baud.
// - Each buffered byte is echoed at the active rate when fetched.
// - An echo starts at least one baud period after its received byte.
// - Reset is active low and held longer than its minimum width.
// - Reset empties the buffer and clears state without touching the display.
// - Serial commands are accepted within 10 ms of reset.
// - Reset reloads the active baud rate from the jumper input.
// - Select line is low for instructions and high for character data.
// - Display direction line stays in the write state permanently.
// - Each display write uses one 3 us enable pulse around stable lines.
// - Each byte goes out whole on the eight-bit parallel bus.
// - Ordinary writes complete within 80 us of the serial byte.
// - Fixed wait times with margin replace polling the display.
// - Every received byte is stored in a 128-byte circular buffer; bytes arriving while it is full are dropped.
// - Next byte is fetched only after the current command and its wait.
// - The module reset command empties the buffer like a hard reset.
// - Plain bytes 0x00-0x07 and 0x10-0xff are written as data.
// - Prefix bytes 0x08-0x0f are not shown; 0x08 opens an instruction, 0x09 a data write, 0x0a-0x0e drop the next byte.
// - Clear and home wait 2.7 ms; every other write waits 80 us.
// - Prefix 0x0f alone is a complete module reset command.
`ifndef LCD_BRIDGE_DEFINES_SVH
`define LCD_BRIDGE_DEFINES_SVH

`define CLK_HZ      250000000
`define CLK_MHZ     250
`define BAUD_LO     19200
`define BAUD_HI     115200
`define T_SHORT_US  80
`define T_LONG_MS   2.7
`define T_EN_US     3
`define EN_CYC      (`T_EN_US * `CLK_MHZ)
`define SETUP_CYC   8
`define HOLD_CYC    8
`define BUF_DEPTH   128
`define TMR_W       20
`define BIT_W       14
`define SETTLE_CYC  2'h3
`define PFX_TOP     5'h01
`define CMD_INSTR   3'h0
`define CMD_DATA    3'h1
`define CMD_RESET   3'h7
`define INS_CLEAR   8'h01
`define INS_HOME    8'h02
`define INS_HOME_M  8'hfe
`define FRAME_BITS  4'h9

`endif

// ---- hw/lcd_bridge_pkg.sv ----
// Types shared by the serial LCD bridge
package lcd_bridge_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_GAP, ST_DECODE, ST_SETUP, ST_ENABLE, ST_HOLD, ST_WAIT
    } proc_state_t;

    typedef enum logic [1:0] {
        MODE_PLAIN, MODE_INSTR, MODE_DATA, MODE_VALUE
    } cmd_mode_t;

    typedef enum logic [1:0] {
        SER_IDLE, SER_START, SER_DATA, SER_STOP
    } ser_state_t;

endpackage : lcd_bridge_pkg

// ---- hw/byte_link_if.sv ----
// Byte link between the bridge core and its serial engines
`timescale 1ns/10ps
`default_nettype none
`include "lcd_bridge_defines.svh"

interface byte_link_if;
    logic [`BIT_W-1:0] bit_cyc;
    logic              line;
    logic [7:0]        data;
    logic              valid;
    logic              busy;

    modport rx (input bit_cyc, line, output data, valid, busy);
    modport tx (input bit_cyc, data, valid, output line, busy);
endinterface : byte_link_if

`default_nettype wire

// ---- hw/async_frame_rx.sv ----
// Serial frame receiver, start/8 data/stop, LSB first
`timescale 1ns/10ps
`default_nettype none
`include "lcd_bridge_defines.svh"

module async_frame_rx
    import lcd_bridge_pkg::*;
(
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    byte_link_if.rx    link
);
    ser_state_t        st_r;
    logic [`BIT_W-1:0] cnt_r;
    logic [2:0]        idx_r;
    logic [7:0]        sh_r;
    logic              vld_r;

    assign link.data  = sh_r;
    assign link.valid = vld_r;
    assign link.busy  = (st_r != SER_IDLE);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_r  <= SER_IDLE;
            cnt_r <= '0;
            idx_r <= '0;
            sh_r  <= '0;
            vld_r <= 1'b0;
        end else begin
            vld_r <= 1'b0;
            case (st_r)
                SER_IDLE: begin
                    if (!link.line) begin
                        cnt_r <= link.bit_cyc >> 1;
                        st_r  <= SER_START;
                    end
                end
                SER_START: begin
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (!link.line) begin
                        cnt_r <= link.bit_cyc - 1'b1;
                        idx_r <= '0;
                        st_r  <= SER_DATA;
                    end else begin
                        st_r <= SER_IDLE;
                    end
                end
                SER_DATA: begin
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        sh_r  <= {link.line, sh_r[7:1]};
                        cnt_r <= link.bit_cyc - 1'b1;
                        idx_r <= idx_r + 1'b1;
                        if (idx_r == 3'h7) begin
                            st_r <= SER_STOP;
                        end
                    end
                end
                SER_STOP: begin
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        vld_r <= link.line;
                        st_r  <= SER_IDLE;
                    end
                end
                default: st_r <= SER_IDLE;
            endcase
        end
    end
endmodule : async_frame_rx

`default_nettype wire

// ---- hw/async_frame_tx.sv ----
// Serial frame transmitter for the echo line
`timescale 1ns/10ps
`default_nettype none
`include "lcd_bridge_defines.svh"

module async_frame_tx (
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    byte_link_if.tx    link
);
    logic [9:0]        sh_r;
    logic [3:0]        left_r;
    logic [`BIT_W-1:0] cnt_r;
    logic              busy_r;

    assign link.line = sh_r[0];
    assign link.busy = busy_r;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sh_r   <= 10'h3ff;
            left_r <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
        end else if (!busy_r) begin
            if (link.valid) begin
                sh_r   <= {1'b1, link.data, 1'b0};
                cnt_r  <= link.bit_cyc - 1'b1;
                left_r <= `FRAME_BITS;
                busy_r <= 1'b1;
            end
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end else if (left_r == '0) begin
            busy_r <= 1'b0;
        end else begin
            sh_r   <= {1'b1, sh_r[9:1]};
            cnt_r  <= link.bit_cyc - 1'b1;
            left_r <= left_r - 1'b1;
        end
    end
endmodule : async_frame_tx

`default_nettype wire

// ---- tb/host_serial_model.sv ----
// Host side serial sender for the bridge bench
`timescale 1ns/10ps
`default_nettype none

module host_serial_model (
    input  wire logic clk_sys_i,
    output logic      line_o
);
    initial line_o = 1'b1;

    // One frame, changed at falling edges, bc cycles a bit
    task automatic send(input logic [7:0] b, input int bc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys_i);
            line_o = fr[i];
            repeat (bc - 1) @(negedge clk_sys_i);
        end
    endtask : send
endmodule : host_serial_model

`default_nettype wire

// ---- tb/serial_to_char_lcd_bridge_tb_top.sv ----
// Bench for the serial LCD bridge
`timescale 1ns/10ps
`default_nettype none
`include "lcd_bridge_defines.svh"

module serial_to_char_lcd_bridge_tb_top;
    localparam int SHORT = 40;
    localparam int LONG  = 200;
    logic       clk_sys_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       baud_sel_n_i = 1'b0;
    wire logic  rx;
    logic       tx_o, instr_data_select_o, lcd_rw_o, lcd_enable_o, ready_o;
    logic [7:0] lcd_parallel_bus_o;
    logic [8:0] wq[$];
    logic [8:0] eq[$];
    logic [7:0] eb, bus_q;
    logic       en_q = 1'b0;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cyc = 0;
    int         fall_cyc, gap_r, en_len, ebc = 16;
    logic [7:0] ins[3] = '{8'h01, 8'h02, 8'h06};
    logic [7:0] dat[3] = '{8'h00, 8'h07, 8'h10};

    initial forever #2 clk_sys_i = ~clk_sys_i;

    host_serial_model host (.clk_sys_i(clk_sys_i), .line_o(rx));

    serial_to_char_lcd_bridge #(.BIT_LO_CYC(64), .BIT_HI_CYC(16),
        .SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_i(rx),
        .baud_sel_n_i(baud_sel_n_i), .tx_o(tx_o),
        .instr_data_select_o(instr_data_select_o), .lcd_rw_o(lcd_rw_o),
        .lcd_enable_o(lcd_enable_o), .lcd_parallel_bus_o(lcd_parallel_bus_o),
        .ready_o(ready_o));

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Display write and echo monitors
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            test_done();
        end
        en_q <= lcd_enable_o;
        if (lcd_enable_o) en_len++;
        if (lcd_enable_o && !en_q) begin
            wq.push_back({instr_data_select_o, lcd_parallel_bus_o});
            bus_q = lcd_parallel_bus_o;
            gap_r = cyc - fall_cyc;
            chk({8'h0, lcd_rw_o}, 9'h000);
        end
        if (!lcd_enable_o && en_q && rst_n_i) begin
            chk({8'h0, en_len == `EN_CYC}, 9'h001);
            chk({1'b0, lcd_parallel_bus_o}, {1'b0, bus_q});
        end
        if (!lcd_enable_o) en_len = 0;
        if (!lcd_enable_o && en_q) fall_cyc = cyc;
    end

    initial forever begin
        @(negedge tx_o);
        repeat (ebc / 2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            repeat (ebc) @(posedge clk_sys_i);
            eb[i] = tx_o;
        end
        repeat (ebc) @(posedge clk_sys_i);
        eq.push_back({1'b0, eb});
    end

    ////////////////////////////////////////////////////////////////////////
    // Access tasks
    task automatic take(input bit echo, input logic [8:0] exp);
        int n;
        n = 0;
        while ((echo ? eq.size() : wq.size()) == 0 && n < 4000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if ((echo ? eq.size() : wq.size()) > 0)
            chk(echo ? eq.pop_front() : wq.pop_front(), exp);
        else
            chk(9'h1ff, exp);
    endtask : take

    task automatic do_reset(input logic sel_n);
        int n;
        @(negedge clk_sys_i);
        baud_sel_n_i = sel_n;
        rst_n_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        n = 0;
        while (ready_o !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk({5'h0, tx_o, lcd_enable_o, lcd_rw_o, ready_o}, 9'h009);
        wq.delete();
        eq.delete();
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        do_reset(1'b0);
        foreach (dat[i]) begin
            host.send(dat[i], 16);
            take(0, {1'b1, dat[i]});
            take(1, {1'b0, dat[i]});
        end
        host.send(8'hff, 16);
        take(0, 9'h1ff);
        take(1, 9'h0ff);
        foreach (ins[i]) begin
            host.send(8'h08, 16);
            host.send(ins[i], 16);
            host.send(8'h43, 16);
            take(0, {1'b0, ins[i]});
            take(0, 9'h143);
            chk({8'h0, i < 2 ? gap_r >= LONG :
                 gap_r >= SHORT && gap_r < LONG}, 9'h001);
            take(1, 9'h008);
            take(1, {1'b0, ins[i]});
            take(1, 9'h043);
        end
        host.send(8'h0a, 16);
        host.send(8'h55, 16);
        host.send(8'h09, 16);
        host.send(8'h0c, 16);
        take(0, 9'h10c);
        host.send(8'h61, 16);
        host.send(8'h0f, 16);
        host.send(8'h62, 16);
        take(0, 9'h161);
        repeat (3000) @(negedge clk_sys_i);
        chk(9'(wq.size()), 9'h000);
        host.send(8'h44, 16);
        take(0, 9'h144);
        host.send(8'h51, 16);
        host.send(8'h52, 16);
        host.send(8'h53, 16);
        take(0, 9'h151);
        do_reset(1'b0);
        repeat (3000) @(negedge clk_sys_i);
        chk(9'(wq.size()), 9'h000);
        do_reset(1'b1);
        ebc = 64;
        host.send(8'h5a, 64);
        take(0, 9'h15a);
        take(1, 9'h05a);
        test_done();
    end
endmodule : serial_to_char_lcd_bridge_tb_top

`default_nettype wire
